// ===== core/cora_device.sv
`timescale 1ns/1ns
`default_nettype none
module cora_device #(
   parameter int NUM_CORES = 6,
   parameter int NUM_VPS = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Requests from the cores
   cora_if.device link,
   // Power and boot state
   output logic [NUM_CORES-1:0] core_powered,
   output logic debug_powered,
   output logic [NUM_CORES*NUM_VPS*32-1:0] boot_vector
);

   localparam int NT = NUM_CORES * NUM_VPS;
   localparam int CW = cora_pkg::CORE_W;
   localparam int VW = cora_pkg::VP_W;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic exists(input logic [CW-1:0] c, input logic [VW-1:0] v);
      return (int'(c) < NUM_CORES) && (int'(v) < NUM_VPS);
   endfunction

   function automatic int slot(input logic [CW-1:0] c, input logic [VW-1:0] v);
      return int'(c) * NUM_VPS + int'(v);
   endfunction

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [CW-1:0] sel_core_q [NT];
   logic [VW-1:0] sel_vp_q [NT];
   logic [cora_pkg::BLK_W-1:0] sel_blk_q [NT];
   logic [cora_pkg::BASE_W-1:0] base_q [NT];
   logic mode_q [NT];
   logic [NUM_CORES-1:0] grant_q;
   logic [cora_pkg::CMD_W-1:0] pcmd_q [NUM_CORES+1];
   logic [NUM_CORES:0] powered_q;
   logic [cora_pkg::DATA_W-1:0] rdata_q;
   logic [NT*32-1:0] boot_vector_q;

   // ----------------------------------------------------------------
   // Requester and redirect decode
   // ----------------------------------------------------------------
   wire req_ok = link.req && exists(link.core, link.vp);
   wire [31:0] own_slot = req_ok ? slot(link.core, link.vp) : 0;
   wire [31:0] own_core_i = req_ok ? int'(link.core) : 0;
   // Redirect fields of the requester's own VP
   wire [CW-1:0] my_core = sel_core_q[own_slot];
   wire [VW-1:0] my_vp = sel_vp_q[own_slot];
   wire [cora_pkg::BLK_W-1:0] my_blk = sel_blk_q[own_slot];

   // A single other-block window, whatever the core count
   wire is_other = link.space == cora_pkg::SP_OTHER;
   wire is_local = link.space == cora_pkg::SP_LOCAL;
   wire [CW-1:0] t_core = is_other ? my_core : link.core;
   wire [VW-1:0] t_vp = is_other ? my_vp : link.vp;
   wire [cora_pkg::BLK_W-1:0] t_blk = is_other ? my_blk : cora_pkg::BLK_LOCAL;

   // Unimplemented core, VP or block falls through to no hit
   wire cfg_hit = (is_local || is_other) && (t_blk == cora_pkg::BLK_LOCAL) && exists(t_core, t_vp);
   wire glb_hit = (link.space == cora_pkg::SP_GLOBAL) || (is_other && t_blk == cora_pkg::BLK_GLOBAL);
   wire [31:0] t_slot = cfg_hit ? slot(t_core, t_vp) : 0;

   // Power controller target: own core, or redirected ring id
   wire pwr_space = (link.space == cora_pkg::SP_PWR_LOCAL) || (link.space == cora_pkg::SP_PWR_OTHER);
   wire [CW-1:0] pwr_ring = (link.space == cora_pkg::SP_PWR_OTHER) ? my_core : link.core;
   wire pwr_dbg = pwr_ring == cora_pkg::DEBUG_RING_ID;
   wire pwr_hit = pwr_space && (link.offset == cora_pkg::OFF_POWER_CMD)
      && ((int'(pwr_ring) < NUM_CORES) || pwr_dbg);
   wire [31:0] pwr_idx = !pwr_hit ? 0 : (pwr_dbg ? NUM_CORES : int'(pwr_ring));

   // ----------------------------------------------------------------
   // Write and read strobes
   // ----------------------------------------------------------------
   // Write grant applies to every write, power commands included; reads always pass
   wire wr_ok = req_ok && link.we && grant_q[own_core_i];
   wire rd_ok = req_ok && !link.we;
   wire hit_sel = cfg_hit && (link.offset == cora_pkg::OFF_TARGET_SEL);
   wire hit_base = cfg_hit && (link.offset == cora_pkg::OFF_BOOT_BASE);
   wire hit_id = cfg_hit && (link.offset == cora_pkg::OFF_IDENTITY);
   wire hit_grant = glb_hit && (link.offset == cora_pkg::OFF_ACCESS_GRANT);
   wire wr_sel = wr_ok && hit_sel;
   wire wr_base = wr_ok && hit_base;
   wire wr_grant = wr_ok && hit_grant;
   wire wr_pwr = wr_ok && pwr_hit;
   wire [cora_pkg::CMD_W-1:0] cmd = link.wdata[cora_pkg::CMD_LSB +: cora_pkg::CMD_W];

   // ----------------------------------------------------------------
   // Read words
   // ----------------------------------------------------------------
   wire [63:0] sel_word = {38'h0, sel_blk_q[t_slot], 10'h0, sel_core_q[t_slot], 5'h0,
      sel_vp_q[t_slot]};
   wire [63:0] base_word = {32'h0, base_q[t_slot], 11'h0, mode_q[t_slot]};
   // Identification shows the core number of the addressed copy
   wire [63:0] id_word = 64'(t_core) << cora_pkg::ID_CORE_LSB;
   wire [63:0] grant_word = 64'(grant_q);
   wire [63:0] pcmd_word = 64'(pcmd_q[pwr_idx]) << cora_pkg::CMD_LSB;

   // Anything without a hit reads as zero
   wire [63:0] rdata_d = !rd_ok ? 64'h0 :
      hit_sel ? sel_word :
      hit_base ? base_word :
      hit_id ? id_word :
      hit_grant ? grant_word :
      pwr_hit ? pcmd_word : 64'h0;

   // ----------------------------------------------------------------
   // Per-VP registers
   // ----------------------------------------------------------------
   // One copy of each per VP, reset together
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < NT; i++)
         begin
            sel_core_q[i] <= '0;
            sel_vp_q[i] <= '0;
            sel_blk_q[i] <= cora_pkg::BLK_LOCAL;
            base_q[i] <= cora_pkg::BOOT_BASE_RST;
            mode_q[i] <= cora_pkg::MODE_RST;
         end
      end
      else
      begin
         if (wr_sel)
         begin
            sel_core_q[t_slot] <= link.wdata[cora_pkg::SEL_CORE_LSB +: CW];
            sel_vp_q[t_slot] <= link.wdata[cora_pkg::SEL_VP_LSB +: VW];
            sel_blk_q[t_slot] <= link.wdata[cora_pkg::SEL_BLK_LSB +: cora_pkg::BLK_W];
         end
         if (wr_base)
         begin
            base_q[t_slot] <= link.wdata[cora_pkg::BASE_LSB +: cora_pkg::BASE_W];
            // Meant to be set once; later changes still take effect
            mode_q[t_slot] <= link.wdata[cora_pkg::MODE_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Global grant and power controller
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         grant_q <= '1;
         powered_q <= '0;
         for (int i = 0; i <= NUM_CORES; i++)
            pcmd_q[i] <= '0;
      end
      else
      begin
         if (wr_grant)
            grant_q <= link.wdata[NUM_CORES-1:0];
         if (wr_pwr)
         begin
            pcmd_q[pwr_idx] <= cmd;
            // Only power-up is acted on here; other commands are just held
            if (cmd == cora_pkg::CMD_POWER_UP)
               powered_q[pwr_idx] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Answer
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         rdata_q <= '0;
      else
         rdata_q <= rdata_d;
   end

   // ----------------------------------------------------------------
   // Boot vectors
   // ----------------------------------------------------------------
   // Low mode drops base bits above 512 MB
   for (genvar g = 0; g < NT; g++)
   begin : g_vec
      wire [31:0] vec_full = {base_q[g], 12'h0};
      wire [31:0] vec_low = {3'h0, base_q[g][cora_pkg::LOW_BASE_W-1:0], 12'h0};
      always_ff @(posedge clock or negedge rstn)
      begin
         if (!rstn)
            boot_vector_q[g*32 +: 32] <= '0;
         else
            boot_vector_q[g*32 +: 32] <= mode_q[g] ? vec_full : vec_low;
      end
   end

   assign link.rdata = rdata_q;
   assign core_powered = powered_q[NUM_CORES-1:0];
   assign debug_powered = powered_q[NUM_CORES];
   assign boot_vector = boot_vector_q;

endmodule
`default_nettype wire

// ===== core/cora_requester.sv
`timescale 1ns/1ns
`default_nettype none
module cora_requester (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Identity of the issuing core and virtual processor
   input wire logic [cora_pkg::CORE_W-1:0] own_core,
   input wire logic [cora_pkg::VP_W-1:0] own_vp,
   // Software port
   input wire logic [cora_pkg::ADDR_W-1:0] addr,
   input wire logic [cora_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [cora_pkg::DATA_W-1:0] rdata,
   output logic unmapped,
   // Link to the register bank
   cora_if.requester link
);

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // Passed straight through so read data can come back one cycle later
   wire cora_pkg::cora_space_e space = cora_pkg::cora_space_e'(addr[15:13]);
   wire space_ok = (space != cora_pkg::SP_NONE6) && (space != cora_pkg::SP_NONE7);
   wire access = wr | rd;

   // Other-core writes go out only as the software ordered them
   assign link.req = access && space_ok;
   assign link.we = wr;
   assign link.core = own_core;
   assign link.vp = own_vp;
   // Address space picked by addr[15:13], passed on as decoded
   assign link.space = space;
   assign link.offset = addr[cora_pkg::OFF_W-1:0];
   assign link.wdata = wdata;

   // ----------------------------------------------------------------
   // Answer and status
   // ----------------------------------------------------------------
   logic rd_pend_q;
   logic unmapped_q;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         rd_pend_q <= 1'b0;
         unmapped_q <= 1'b0;
      end
      else
      begin
         rd_pend_q <= rd && space_ok;
         if (access && !space_ok)
            unmapped_q <= 1'b1;
      end
   end

   // Unmapped reads see zero
   assign rdata = rd_pend_q ? link.rdata : '0;
   assign unmapped = unmapped_q;

endmodule
`default_nettype wire

// ===== pkg/cora_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cora_if;
   // Request, one cycle long
   logic req;
   logic we;
   logic [cora_pkg::CORE_W-1:0] core;
   logic [cora_pkg::VP_W-1:0] vp;
   cora_pkg::cora_space_e space;
   logic [cora_pkg::OFF_W-1:0] offset;
   logic [cora_pkg::DATA_W-1:0] wdata;
   // Answer, cycle after the request
   logic [cora_pkg::DATA_W-1:0] rdata;

   modport requester (output req, output we, output core, output vp, output space, output offset,
      output wdata, input rdata);
   modport device (input req, input we, input core, input vp, input space, input offset,
      input wdata, output rdata);
endinterface
`default_nettype wire

// ===== pkg/cora_pkg.sv
`default_nettype none
package cora_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int DATA_W = 64;
   localparam int OFF_W = 13;
   localparam int ADDR_W = 16;
   localparam int CORE_W = 6;
   localparam int VP_W = 3;
   localparam int BLK_W = 2;
   localparam int CMD_W = 4;
   localparam int BASE_W = 20;

   // ----------------------------------------------------------------
   // Register offsets within an 8 KB block
   // ----------------------------------------------------------------
   localparam logic [OFF_W-1:0] OFF_POWER_CMD = 13'h0000;
   localparam logic [OFF_W-1:0] OFF_TARGET_SEL = 13'h0018;
   localparam logic [OFF_W-1:0] OFF_BOOT_BASE = 13'h0020;
   localparam logic [OFF_W-1:0] OFF_IDENTITY = 13'h0028;
   localparam logic [OFF_W-1:0] OFF_ACCESS_GRANT = 13'h0120;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SEL_CORE_LSB = 8;
   localparam int SEL_VP_LSB = 0;
   localparam int SEL_BLK_LSB = 24;
   localparam int BASE_LSB = 12;
   localparam int MODE_BIT = 0;
   localparam int ID_CORE_LSB = 0;
   localparam int CMD_LSB = 0;

   // ----------------------------------------------------------------
   // Encodings and reset values
   // ----------------------------------------------------------------
   localparam logic [BLK_W-1:0] BLK_LOCAL = 2'h0;
   localparam logic [BLK_W-1:0] BLK_GLOBAL = 2'h1;
   localparam logic [CMD_W-1:0] CMD_POWER_UP = 4'h3;
   localparam logic [CORE_W-1:0] DEBUG_RING_ID = 6'h23;
   localparam logic [BASE_W-1:0] BOOT_BASE_RST = 20'h1fc00;
   localparam logic MODE_RST = 1'b0;
   // Low window keeps only the base bits below 512 MB
   localparam int LOW_BASE_W = 17;

   // Address map seen by the requester: addr[15:13] picks the space
   typedef enum logic [2:0] {
      SP_GLOBAL = 3'b000,
      SP_LOCAL = 3'b001,
      SP_OTHER = 3'b010,
      SP_DEBUG = 3'b011,
      SP_PWR_LOCAL = 3'b100,
      SP_PWR_OTHER = 3'b101,
      SP_NONE6 = 3'b110,
      SP_NONE7 = 3'b111
   } cora_space_e;

endpackage
`default_nettype wire

// ===== tb/cora_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module cora_assertions #(
   parameter int NUM_CORES = 6,
   parameter int NUM_VPS = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Link signals
   input wire logic req,
   input wire logic we,
   input wire logic [cora_pkg::CORE_W-1:0] core,
   input wire logic [cora_pkg::VP_W-1:0] vp,
   input wire cora_pkg::cora_space_e space,
   input wire logic [cora_pkg::OFF_W-1:0] offset,
   input wire logic [cora_pkg::DATA_W-1:0] wdata,
   input wire logic [cora_pkg::DATA_W-1:0] rdata
);
   // ----
   // Shadow state, indexed {core, vp}
   // ----
   logic [63:0] sel_q [32];
   logic [63:0] base_q [32];
   logic [7:0] grant_q;
   wire own_ok = int'(core) < NUM_CORES && int'(vp) < NUM_VPS;
   wire [4:0] own_i = {core[2:0], vp[1:0]};
   wire [63:0] own_sel = own_ok ? sel_q[own_i] : 64'h0;
   wire [5:0] tgt_core = own_sel[13:8];
   wire [4:0] tgt_i = {tgt_core[2:0], own_sel[1:0]};
   wire tgt_ok = own_sel[25:24] == 2'h0 && int'(tgt_core) < NUM_CORES && int'(own_sel[2:0]) < NUM_VPS;
   wire [63:0] own_base = base_q[own_i];
   wire [63:0] tgt_base = tgt_ok ? base_q[tgt_i] : 64'h0;
   // Grant gates every shadow update, as it gates the bank
   wire wr_ok = req && we && own_ok && grant_q[core[2:0]];
   wire is_other = space == cora_pkg::SP_OTHER;
   wire base_wr = wr_ok && offset == cora_pkg::OFF_BOOT_BASE && (space == cora_pkg::SP_LOCAL || is_other && tgt_ok);
   wire sel_wr = wr_ok && offset == cora_pkg::OFF_TARGET_SEL && space == cora_pkg::SP_LOCAL;
   wire grant_wr = wr_ok && offset == cora_pkg::OFF_ACCESS_GRANT && space == cora_pkg::SP_GLOBAL;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         grant_q <= 8'h3f;
         sel_q <= '{default: 64'h0};
         base_q <= '{default: 64'h1fc0_0000};
      end
      else
      begin
         if (sel_wr)
            sel_q[own_i] <= wdata & 64'h0300_3f07;
         if (base_wr)
            base_q[is_other ? tgt_i : own_i] <= wdata & 64'hffff_f001;
         if (grant_wr)
            grant_q <= {2'h0, wdata[5:0]};
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence rd_at(s, o);
      req && !we && own_ok && space == s && offset == o;
   endsequence
   sel_back_a: assert property (rd_at(cora_pkg::SP_LOCAL, 13'h18) |=> rdata == $past(own_sel))
      else $error("redirect read-back wrong");
   own_base_a: assert property (rd_at(cora_pkg::SP_LOCAL, 13'h20) |=> rdata == $past(own_base))
      else $error("own boot base wrong");
   other_base_a: assert property (rd_at(cora_pkg::SP_OTHER, 13'h20) |=> rdata == $past(tgt_base))
      else $error("redirected boot base wrong");
   own_id_a: assert property (rd_at(cora_pkg::SP_LOCAL, 13'h28) |=> rdata[5:0] == $past(core))
      else $error("own core number wrong");
   other_id_a: assert property (rd_at(cora_pkg::SP_OTHER, 13'h28) ##0 tgt_ok |=> rdata[5:0] == $past(tgt_core))
      else $error("redirected identity wrong");
   grant_back_a: assert property (rd_at(cora_pkg::SP_GLOBAL, 13'h120) |=> {2'h0, rdata[5:0]} == $past(grant_q))
      else $error("grant read-back wrong");
   no_block_a: assert property (rd_at(cora_pkg::SP_OTHER, 13'h28) ##0 own_sel[25:24] > 2'h1 |=> rdata == 64'h0)
      else $error("absent block read not zero");
   debug_space_a: assert property (req && !we && space == cora_pkg::SP_DEBUG |=> rdata == 64'h0)
      else $error("debug space read not zero");
endmodule
`default_nettype wire

// ===== tb/tb_core_other_redirect_access.sv
`timescale 1ns/1ns
`default_nettype none
module tb_core_other_redirect_access;
   logic clock;
   logic rstn = 1'b0;
   logic [5:0] own_core = 6'h0;
   logic [2:0] own_vp = 3'h0;
   logic [15:0] addr = 16'h0;
   logic [63:0] wdata = 64'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [63:0] rdata;
   logic unmapped;
   logic [5:0] core_powered;
   logic debug_powered;
   logic [767:0] boot_vector;
   int fails = 0;
   int n_tests = 0;
   cora_if link();
   cora_requester i_cora_requester (.clock(clock), .rstn(rstn), .own_core(own_core), .own_vp(own_vp),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .unmapped(unmapped), .link(link));
   cora_device #(.NUM_CORES(6), .NUM_VPS(4)) i_cora_device (.clock(clock), .rstn(rstn), .link(link),
      .core_powered(core_powered), .debug_powered(debug_powered), .boot_vector(boot_vector));
   cora_assertions #(.NUM_CORES(6), .NUM_VPS(4)) i_cora_assertions (.clock(clock), .rstn(rstn),
      .req(link.req), .we(link.we), .core(link.core), .vp(link.vp), .space(link.space),
      .offset(link.offset), .wdata(link.wdata), .rdata(link.rdata));
   // ----
   // Bus tasks
   // ----
   task automatic ck(input string n, input logic [63:0] e, input logic [63:0] g);
      n_tests++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic op(input logic w, input logic [15:0] a, input logic [63:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge clock);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask
   task automatic rd_ck(input logic [15:0] a, input logic [63:0] m, input logic [63:0] e);
      op(1'b0, a, 64'h0);
      ck($sformatf("rdata at %h", a), e, rdata & m);
   endtask
   task automatic who(input logic [5:0] c, input logic [2:0] v);
      @(posedge clock);
      own_core <= c;
      own_vp <= v;
   endtask
   // Vector flop trails the base register by one cycle
   task automatic slot_ck(input int s, input logic [31:0] e);
      repeat (2) @(posedge clock);
      #1;
      ck($sformatf("boot_vector %0d", s), {32'h0, e}, {32'h0, boot_vector[s*32 +: 32]});
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_reset();
      who(6'h2, 3'h1);
      for (int s = 0; s < 24; s++)
         slot_ck(s, 32'h1fc0_0000);
      ck("core_powered", 64'h0, 64'(core_powered));
      rd_ck(16'h2020, '1, 64'h1fc0_0000);
      rd_ck(16'h2028, 64'h3f, 64'h2);
      rd_ck(16'h0120, 64'h3f, 64'h3f);
   endtask
   task automatic t_redirect();
      who(6'h1, 3'h0);
      op(1'b1, 16'h2018, 64'h102);
      rd_ck(16'h2018, '1, 64'h102);
      op(1'b1, 16'h4020, 64'h8000_0001);
      slot_ck(6, 32'h8000_0000);
      rd_ck(16'h4020, '1, 64'h8000_0001);
      rd_ck(16'h2020, '1, 64'h1fc0_0000);
      who(6'h0, 3'h0);
      op(1'b1, 16'h2018, 64'h100);
      op(1'b1, 16'h4020, 64'h2000_0000);
      slot_ck(4, 32'h0);
      op(1'b1, 16'h4020, 64'h2000_0001);
      slot_ck(4, 32'h2000_0000);
      op(1'b1, 16'h2018, 64'h503);
      op(1'b1, 16'h4020, 64'hffff_f001);
      slot_ck(23, 32'hffff_f000);
      slot_ck(0, 32'h1fc0_0000);
      rd_ck(16'h4028, 64'h3f, 64'h5);
   endtask
   // Cores 0, 1 and 5 and the debug ring come up here, before anything configures them
   task automatic t_power();
      who(6'h0, 3'h0);
      op(1'b1, 16'h2018, 64'h100);
      op(1'b1, 16'ha000, 64'h3);
      ck("core_powered", 64'h02, 64'(core_powered));
      op(1'b1, 16'h2018, 64'h400);
      op(1'b1, 16'ha000, 64'h2);
      op(1'b1, 16'h2018, 64'h500);
      op(1'b1, 16'ha000, 64'h3);
      op(1'b1, 16'h2018, 64'h2300);
      op(1'b1, 16'ha000, 64'h3);
      op(1'b1, 16'h8000, 64'h3);
      ck("core_powered", 64'h23, 64'(core_powered));
      ck("debug_powered", 64'h1, 64'(debug_powered));
      rd_ck(16'ha000, 64'hf, 64'h3);
   endtask
   task automatic t_grant();
      who(6'h2, 3'h0);
      op(1'b1, 16'h0120, 64'h3b);
      rd_ck(16'h0120, 64'h3f, 64'h3b);
      op(1'b1, 16'h2020, 64'h1234_5000);
      op(1'b1, 16'h8000, 64'h3);
      rd_ck(16'h2020, '1, 64'h1fc0_0000);
      ck("core_powered", 64'h23, 64'(core_powered));
      who(6'h0, 3'h0);
      op(1'b1, 16'h0120, 64'h3f);
   endtask
   task automatic t_missing();
      op(1'b1, 16'h2018, 64'h0200_0100);
      rd_ck(16'h4028, '1, 64'h0);
      op(1'b1, 16'h4020, 64'h4000_0001);
      op(1'b1, 16'h2018, 64'h0100_0000);
      rd_ck(16'h4120, 64'h3f, 64'h3f);
      op(1'b1, 16'h2018, 64'h700);
      rd_ck(16'h4020, '1, 64'h0);
      op(1'b1, 16'h2018, 64'h100);
      rd_ck(16'h4020, '1, 64'h2000_0001);
      rd_ck(16'h6028, '1, 64'h0);
      op(1'b1, 16'hc000, 64'h0);
      rd_ck(16'he018, '1, 64'h0);
      ck("unmapped", 64'h1, 64'(unmapped));
   endtask
   // Reset in mid-run clears power state and the sticky flag
   task automatic t_rerun();
      @(posedge clock);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      ck("core_powered", 64'h0, 64'(core_powered));
      ck("debug_powered", 64'h0, 64'(debug_powered));
      ck("unmapped", 64'h0, 64'(unmapped));
      @(posedge clock);
      rstn <= 1'b1;
      slot_ck(23, 32'h1fc0_0000);
      rd_ck(16'h0120, 64'h3f, 64'h3f);
      rd_ck(16'h2018, '1, 64'h0);
   endtask
   task automatic complete_run();
      if (fails == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial
   begin
      #50000;
      fails++;
      complete_run();
   end
   initial
   begin
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      t_reset();
      t_power();
      t_redirect();
      t_grant();
      t_missing();
      t_rerun();
      complete_run();
   end
endmodule
`default_nettype wire
